// File: alarm_output_conditioner.sv
// Three-channel alarm output conditioner with Avalon-MM registers
//
// What this block does
// - Per-alarm hysteresis 0.1 to 999.2, default 0.2
// - Decimal point 0 divides hysteresis by ten
// - Config writes accepted only while operation stopped
// - Standby holds alarm until range left, re-entered
// - Alarm cancels standby; start, value, shift re-arm
// - Set point, bank, type change also re-arm
// - Latch enabled keeps alarm on; default off
// - Latch-cancel, software reset, type 0 or latch-off config clear latch
// - Polarity 0 passes state, 1 inverts it
// - Output forced off about 3 s after power-up
// - ON/OFF delays 0 to 999 s feed status
// - ON delay applies after power-on, software reset
// - Pulses not longer than delay are suppressed
// - Toggle during delay restarts the measurement
// - Selection 0 ramping set point, 1 target
// - Selection only deviation, ramp on, self-tuning off
// - Type zero disables all alarm functions
// - Per-channel alarm status is readable
// - Polarity matters only when routed to output
// - Types 5, 6, 7, A, B use standby; others bypass
`timescale 1ns/1ps
`default_nettype none
module alarm_output_conditioner #(
    parameter int TICKS_PER_SEC = alarm_pkg::TICKS_PER_SEC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] process_value,
    output logic [2:0] alarm_out,
    output logic [2:0] alarm_status
);
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic run;
        logic ramp_en;
        logic self_tuning;
        logic [1:0] dp;
        logic [1:0] bank;
        logic [15:0] ramp_sp;
        logic [15:0] target_sp;
        logic [15:0] shift;
        logic [2:0][7:0] cfg;
        logic [2:0][13:0] hyst;
        logic [2:0][9:0] on_dly;
        logic [2:0][9:0] off_dly;
        logic [2:0][15:0] aval;
        logic [2:0] raw;
        logic [2:0] armed;
        logic [2:0] seen_out;
        logic [2:0] latched;
        logic [2:0] out;
        logic [2:0] status;
        logic [31:0] div;
        logic tick;
        logic [1:0] pu_cnt;
        logic pu_hold;
    } main_state_t;

    main_state_t st;
    main_state_t next_st;
    logic wr;
    logic sreset;
    logic cancel;
    logic [31:0] rd_mux;
    logic [31:0] wdat;
    logic [2:0] gated;
    logic [2:0] delayed;
    logic [2:0] rearm;
    logic [2:0] func;
    logic signed [17:0] pv_eff;
    logic signed [17:0] sp;
    logic signed [17:0] h;
    logic [3:0] typ;

    if (TICKS_PER_SEC < 2) begin : g_chk
        $error("TICKS_PER_SEC must be at least 2");
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] off);
        ch_addr = 8'(alarm_pkg::CH_BASE + ch * alarm_pkg::CH_STRIDE + off);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    function automatic logic is_standby(input logic [3:0] t);
        is_standby = (t >= 4'h5 && t <= 4'h7) || t == 4'hA || t == 4'hB;
    endfunction

    // Raw comparison with hysteresis; x is the alarm value
    function automatic logic evaluate(input logic [3:0] t, input logic prev,
                                      input logic signed [17:0] pv,
                                      input logic signed [17:0] s,
                                      input logic signed [17:0] x,
                                      input logic signed [17:0] hy);
        logic signed [17:0] hi;
        logic signed [17:0] lo;
        logic on;
        logic off;
        hi = s + x;
        lo = s - x;
        on = 1'b0;
        off = 1'b1;
        case (t)
            4'h1, 4'h5: begin
                on = pv > hi || pv < lo;
                off = pv < hi - hy && pv > lo + hy;
            end
            4'h2, 4'h6: begin
                on = pv > hi;
                off = pv < hi - hy;
            end
            4'h3, 4'h7: begin
                on = pv < lo;
                off = pv > lo + hy;
            end
            4'h4: begin
                on = pv < hi && pv > lo;
                off = pv > hi + hy || pv < lo - hy;
            end
            4'h8, 4'hA: begin
                on = pv > x;
                off = pv < x - hy;
            end
            4'h9, 4'hB: begin
                on = pv < x;
                off = pv > x + hy;
            end
            default: begin
                on = 1'b0;
                off = 1'b1;
            end
        endcase
        evaluate = prev ? !off : on;
    endfunction

    // ****************************************
    // Delay filters
    // ****************************************
    for (genvar g = 0; g < 3; g++) begin : g_ch
        alarm_delay #(
            .CNT_W(10)
        ) u_delay (
            .clk_sys(clk_sys),
            .rst(rst),
            .clear(sreset),
            .tick(st.tick),
            .raw(gated[g]),
            .on_delay(st.on_dly[g]),
            .off_delay(st.off_dly[g]),
            .delayed(delayed[g])
        );
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        sp = '0;
        h = '0;
        typ = '0;
        rearm = '0;
        gated = '0;
        func = '0;
        rd_mux = '0;
        wr = avs_write && !st.waitrequest;
        pv_eff = 18'(signed'(process_value)) + 18'(signed'(st.shift));
        case (avs_address)
            alarm_pkg::CTRL: begin
                rd_mux[alarm_pkg::CTRL_RUN] = st.run;
                rd_mux[alarm_pkg::CTRL_RAMP] = st.ramp_en;
                rd_mux[alarm_pkg::CTRL_TUNE] = st.self_tuning;
                rd_mux[alarm_pkg::CTRL_DP +: 2] = st.dp;
            end
            alarm_pkg::STATUS: begin
                rd_mux = {19'h0, st.pu_hold, st.latched, st.armed, st.raw, st.status};
            end
            alarm_pkg::RAMP_SP: rd_mux = {16'h0, st.ramp_sp};
            alarm_pkg::TARGET_SP: rd_mux = {16'h0, st.target_sp};
            alarm_pkg::INPUT_SHIFT: rd_mux = {16'h0, st.shift};
            alarm_pkg::BANK: rd_mux = {30'h0, st.bank};
            default: begin
                for (int i = 0; i < 3; i++) begin
                    if (avs_address == ch_addr(i, alarm_pkg::CH_CFG)) begin
                        rd_mux = {24'h0, st.cfg[i]};
                    end
                    if (avs_address == ch_addr(i, alarm_pkg::CH_HYST)) begin
                        rd_mux = {18'h0, st.hyst[i]};
                    end
                    if (avs_address == ch_addr(i, alarm_pkg::CH_DELAY)) begin
                        rd_mux = {6'h0, st.off_dly[i], 6'h0, st.on_dly[i]};
                    end
                    if (avs_address == ch_addr(i, alarm_pkg::CH_VALUE)) begin
                        rd_mux = {16'h0, st.aval[i]};
                    end
                end
            end
        endcase
        wdat = merge(rd_mux, avs_writedata, avs_byteenable);
        sreset = wr && avs_address == alarm_pkg::CTRL && wdat[alarm_pkg::CTRL_SRESET];
        cancel = wr && avs_address == alarm_pkg::CTRL && wdat[alarm_pkg::CTRL_CANCEL];
        // One wait state: the answer comes the cycle after the request
        next_st.waitrequest = !((avs_read || avs_write) && st.waitrequest);
        if ((avs_read || avs_write) && st.waitrequest) begin
            next_st.readdata = rd_mux;
        end
        // Register writes
        if (wr) begin
            case (avs_address)
                alarm_pkg::CTRL: begin
                    next_st.run = wdat[alarm_pkg::CTRL_RUN];
                    next_st.ramp_en = wdat[alarm_pkg::CTRL_RAMP];
                    next_st.self_tuning = wdat[alarm_pkg::CTRL_TUNE];
                    next_st.dp = wdat[alarm_pkg::CTRL_DP +: 2];
                    if (wdat[alarm_pkg::CTRL_RUN] && !st.run) begin
                        rearm = '1;
                    end
                end
                alarm_pkg::RAMP_SP: begin
                    next_st.ramp_sp = wdat[15:0];
                    rearm = '1;
                end
                alarm_pkg::TARGET_SP: begin
                    next_st.target_sp = wdat[15:0];
                    rearm = '1;
                end
                alarm_pkg::INPUT_SHIFT: begin
                    next_st.shift = wdat[15:0];
                    rearm = '1;
                end
                alarm_pkg::BANK: begin
                    next_st.bank = wdat[1:0];
                    rearm = '1;
                end
                default: begin
                    for (int i = 0; i < 3; i++) begin
                        if (avs_address == ch_addr(i, alarm_pkg::CH_VALUE)) begin
                            next_st.aval[i] = wdat[15:0];
                            rearm[i] = 1'b1;
                        end
                        // Settings are locked while running
                        if (!st.run) begin
                            if (avs_address == ch_addr(i, alarm_pkg::CH_CFG)) begin
                                next_st.cfg[i] = wdat[7:0];
                                rearm[i] = wdat[3:0] != st.cfg[i][3:0];
                            end
                            if (avs_address == ch_addr(i, alarm_pkg::CH_HYST) &&
                                wdat[13:0] >= alarm_pkg::HYST_MIN &&
                                wdat[13:0] <= alarm_pkg::HYST_MAX && wdat[31:14] == '0) begin
                                next_st.hyst[i] = wdat[13:0];
                            end
                            if (avs_address == ch_addr(i, alarm_pkg::CH_DELAY)) begin
                                next_st.on_dly[i] = wdat[9:0] > alarm_pkg::DELAY_MAX ?
                                    alarm_pkg::DELAY_MAX : wdat[9:0];
                                next_st.off_dly[i] =
                                    wdat[alarm_pkg::DLY_OFF +: 10] > alarm_pkg::DELAY_MAX ?
                                    alarm_pkg::DELAY_MAX : wdat[alarm_pkg::DLY_OFF +: 10];
                            end
                        end
                    end
                end
            endcase
        end
        if (sreset) begin
            rearm = '1;
        end
        // One-second timebase and power-up hold
        next_st.tick = 1'b0;
        if (st.div == 32'(TICKS_PER_SEC - 1)) begin
            next_st.div = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 32'h0000_0001;
        end
        if (st.tick && st.pu_hold) begin
            next_st.pu_cnt = st.pu_cnt + 2'h1;
            next_st.pu_hold = (st.pu_cnt + 2'h1) != alarm_pkg::POWERUP_S;
        end
        // Per-channel pipeline
        for (int i = 0; i < 3; i++) begin
            typ = st.cfg[i][3:0];
            // Target when ramp off, or for selected deviation types with self-tuning off
            if (st.ramp_en && !(typ >= 4'h1 && typ <= 4'h7 && !st.self_tuning &&
                st.cfg[i][alarm_pkg::CFG_SPSEL])) begin
                sp = 18'(signed'(st.ramp_sp));
            end else begin
                sp = 18'(signed'(st.target_sp));
            end
            // Whole-digit sensors read the setting with one decimal
            if (st.dp == 2'h0) begin
                h = 18'(st.hyst[i] / alarm_pkg::HYST_DIV);
            end else begin
                h = 18'(st.hyst[i]);
            end
            next_st.raw[i] = typ != 4'h0 && !sreset &&
                evaluate(typ, st.raw[i], pv_eff, sp, 18'(signed'(st.aval[i])), h);
            gated[i] = st.raw[i] && (!is_standby(typ) || !st.armed[i] ||
                st.seen_out[i]);
            if (!st.raw[i]) begin
                next_st.seen_out[i] = 1'b1;
            end
            if (gated[i]) begin
                next_st.armed[i] = 1'b0;
            end
            if (rearm[i]) begin
                next_st.armed[i] = 1'b1;
                next_st.seen_out[i] = 1'b0;
            end
            // A new alarm in the latch-cancel cycle still latches; software reset blocks it
            next_st.latched[i] = typ != 4'h0 && st.cfg[i][alarm_pkg::CFG_LATCH] &&
                ((delayed[i] && !sreset) ||
                (st.latched[i] && !cancel && !sreset));
            func[i] = typ != 4'h0 && (delayed[i] || st.latched[i]);
            next_st.status[i] = func[i];
            next_st.out[i] = !st.pu_hold && (func[i] ^ (st.cfg[i][alarm_pkg::CFG_POL] &&
                st.cfg[i][alarm_pkg::CFG_ROUTED]));
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
            st.waitrequest <= 1'b1;
            st.armed <= 3'h7;
            st.pu_hold <= 1'b1;
            for (int i = 0; i < 3; i++) begin
                st.cfg[i] <= {4'h0, alarm_pkg::TYPE_RESET};
                st.hyst[i] <= alarm_pkg::HYST_RESET;
            end
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitrequest;
    assign alarm_out = st.out;
    assign alarm_status = st.status;
endmodule
`default_nettype wire

// File: alarm_pkg.sv
// Shared constants for the alarm output conditioner
package alarm_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL = 8'h00;
    localparam logic [7:0] STATUS = 8'h04;
    localparam logic [7:0] RAMP_SP = 8'h08;
    localparam logic [7:0] TARGET_SP = 8'h0C;
    localparam logic [7:0] INPUT_SHIFT = 8'h10;
    localparam logic [7:0] BANK = 8'h14;
    localparam logic [7:0] CH_BASE = 8'h40;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] CH_CFG = 8'h00;
    localparam logic [7:0] CH_HYST = 8'h04;
    localparam logic [7:0] CH_DELAY = 8'h08;
    localparam logic [7:0] CH_VALUE = 8'h0C;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_RUN = 0;
    localparam int CTRL_CANCEL = 1;
    localparam int CTRL_SRESET = 2;
    localparam int CTRL_RAMP = 3;
    localparam int CTRL_TUNE = 4;
    localparam int CTRL_DP = 5;
    localparam int CFG_LATCH = 4;
    localparam int CFG_POL = 5;
    localparam int CFG_SPSEL = 6;
    localparam int CFG_ROUTED = 7;
    localparam int DLY_OFF = 16;
    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [3:0] TYPE_RESET = 4'h2;
    localparam logic [13:0] HYST_RESET = 14'h0002;
    localparam logic [13:0] HYST_MIN = 14'h0001;
    localparam logic [13:0] HYST_MAX = 14'h2708;
    localparam logic [9:0] DELAY_MAX = 10'h3E7;
    localparam logic [3:0] HYST_DIV = 4'hA;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEC_NS = 1000000000;
    localparam int TICKS_PER_SEC = SEC_NS / CLK_PERIOD_NS;
    localparam logic [1:0] POWERUP_S = 2'h3;
endpackage

// File: alarm_delay.sv
// Per-alarm ON/OFF delay filter, measured in whole seconds
`timescale 1ns/1ps
`default_nettype none
module alarm_delay #(
    parameter int CNT_W = 10
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    input wire logic raw,
    input wire logic [CNT_W-1:0] on_delay,
    input wire logic [CNT_W-1:0] off_delay,
    output logic delayed
);
    typedef struct packed {
        logic out;
        logic prev_in;
        logic [CNT_W-1:0] cnt;
    } delay_state_t;

    delay_state_t st;
    delay_state_t next_st;
    logic [CNT_W-1:0] lim;

    if (CNT_W < 10) begin : g_chk
        $error("CNT_W too narrow for 999 s");
    end

    // ****************************************
    // Filter
    // ****************************************
    always_comb begin
        next_st = st;
        lim = raw ? on_delay : off_delay;
        if (clear) begin
            next_st = '0;
        end else begin
            next_st.prev_in = raw;
            if (raw != st.prev_in) begin
                next_st.cnt = '0;
            end else if (tick && st.cnt != '1) begin
                next_st.cnt = st.cnt + 1'b1;
            end
            // Must stay for strictly longer than the delay
            if (raw != st.out) begin
                if (lim == '0 || (raw == st.prev_in && st.cnt > lim)) begin
                    next_st.out = raw;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign delayed = st.out;
endmodule
`default_nettype wire

// File: alarm_load_model.sv
// Load relay switched by the alarm outputs
`timescale 1ns/1ps
`default_nettype none
// ****
// Relay model
// ****
module alarm_load_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] drive,
    output logic [2:0] load_on
);
    // One-cycle pickup stands in for coil delay; contacts open in reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_on <= 3'h0;
        end else begin
            load_on <= drive;
        end
    end
endmodule
`default_nettype wire

// File: alarm_output_conditioner_checker.sv
// Bus and power-up checks for the alarm conditioner
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module alarm_output_conditioner_checker #(
    parameter int TICKS_PER_SEC = 10
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [15:0] process_value,
    input wire logic [2:0] alarm_out,
    input wire logic [2:0] alarm_status
);
    localparam int HOLD = 3 * TICKS_PER_SEC;
    int hold_cnt;
    // Saturates so the count cannot wrap back into the hold window
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_cnt <= 0;
        end else if (hold_cnt < HOLD) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd(a);
        avs_read && avs_waitrequest && avs_address == a;
    endsequence
    sequence s_idle;
        !avs_read && !avs_write && avs_waitrequest;
    endsequence
    AST_ANSWER_ONE: assert property (s_take |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    AST_ANSWER_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    AST_NO_SPURIOUS: assert property (s_idle |=> avs_waitrequest)
        else $error("answer without request");
    AST_READ_HOLD: assert property (s_idle |=> $stable(avs_readdata))
        else $error("read data moved while idle");
    AST_UNMAPPED: assert property (s_rd(8'h20) |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_CMD_READ_ZERO: assert property (s_rd(8'h00) |=> avs_readdata[2:1] == 2'h0)
        else $error("command bits read back set");
    AST_HOLD_OFF: assert property (hold_cnt < HOLD - 1 |-> alarm_out == 3'h0)
        else $error("output closed during power-up hold");
    AST_FIRST_IDLE: assert property (hold_cnt == 0 |-> avs_waitrequest)
        else $error("bus answered right after reset");
endmodule
bind alarm_output_conditioner alarm_output_conditioner_checker #(
    .TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .process_value(process_value), .alarm_out(alarm_out), .alarm_status(alarm_status));
`default_nettype wire

// File: tb_alarm_output_conditioner.sv
// Self-checking bench for the alarm output conditioner
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
// ****
// Bench
// ****
module tb_alarm_output_conditioner;
    localparam int TPS = 10;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] process_value = 16'h0000;
    logic [2:0] alarm_out;
    logic [2:0] alarm_status;
    logic [2:0] load_on;
    logic [31:0] q;
    logic seen;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int pv;
    int e;
    int exp_q[$];
    alarm_output_conditioner #(.TICKS_PER_SEC(TPS)) u_alarm_output_conditioner (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .process_value(process_value),
        .alarm_out(alarm_out), .alarm_status(alarm_status));
    alarm_load_model u_alarm_load_model (.clk_sys(clk_sys), .rst(rst),
        .drive(alarm_out), .load_on(load_on));
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    function automatic logic [7:0] ch(int i, logic [7:0] off);
        return alarm_pkg::CH_BASE + 8'(i) * alarm_pkg::CH_STRIDE + off;
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic set_pv(int v);
        @(posedge clk_sys);
        process_value <= 16'(v);
    endtask
    initial begin
        void'($urandom(55725));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        process_value <= 16'h0064;
        bus(0, ch(0, alarm_pkg::CH_CFG), 0);
        `CHK("cfg0", 32'h0000_0002, q)
        bus(0, ch(0, alarm_pkg::CH_HYST), 0);
        `CHK("hyst0", 32'h0000_0002, q)
        bus(0, ch(0, alarm_pkg::CH_DELAY), 0);
        `CHK("delay0", 32'h0000_0000, q)
        bus(0, 8'h20, 0);
        `CHK("unmapped", 32'h0000_0000, q)
        `CHK("held out", 3'h0, alarm_out)
        `CHK("status", 3'h7, alarm_status)
        cyc(30);
        `CHK("out", 3'h7, alarm_out)
        `CHK("load", 3'h7, load_on)
        bus(0, alarm_pkg::STATUS, 0);
        `CHK("status reg", 3'h7, q[2:0])
        $display("test reset done");
        bus(1, alarm_pkg::CTRL, 32'h0000_0001);
        bus(1, ch(0, alarm_pkg::CH_CFG), 32'h0000_00A2);
        bus(0, ch(0, alarm_pkg::CH_CFG), 0);
        `CHK("cfg run", 32'h0000_0002, q)
        bus(1, alarm_pkg::CTRL, 32'h0000_0000);
        bus(1, ch(0, alarm_pkg::CH_CFG), 32'h0000_00A2);
        bus(0, ch(0, alarm_pkg::CH_CFG), 0);
        `CHK("cfg stop", 32'h0000_00A2, q)
        cyc(4);
        `CHK("inverted", 3'h6, alarm_out)
        $display("test polarity done");
        // Values stay clear of the limit so the hysteresis band never matters
        for (int i = 0; i < 24; i++) begin
            pv = 50 + int'($urandom_range(250));
            if ($urandom_range(1) == 1) begin
                pv = -pv;
            end
            exp_q.push_back(pv > 0 ? 7 : 0);
            set_pv(pv);
            cyc(5);
            e = exp_q.pop_front();
            `CHK("rand status", 3'(e), alarm_status)
            `CHK("rand out", 3'(e) ^ 3'h1, alarm_out)
        end
        bus(1, ch(1, alarm_pkg::CH_HYST), 32'h0000_01F4);
        set_pv(100);
        cyc(5);
        set_pv(-30);
        cyc(5);
        `CHK("hyst band", 1'b1, alarm_status[1])
        `CHK("hyst ch0", 1'b0, alarm_status[0])
        set_pv(-60);
        cyc(5);
        `CHK("hyst off", 1'b0, alarm_status[1])
        $display("test compare done");
        bus(1, ch(1, alarm_pkg::CH_DELAY), 32'h0000_0002);
        seen = 1'b0;
        set_pv(100);
        for (int i = 0; i < 25; i++) begin
            @(posedge clk_sys);
            seen = seen | alarm_status[1];
            if (i == 13) begin
                process_value <= 16'hFF9C;
            end
        end
        `CHK("short pulse", 1'b0, seen)
        set_pv(100);
        cyc(13);
        set_pv(-100);
        set_pv(100);
        cyc(17);
        `CHK("restart", 1'b0, alarm_status[1])
        cyc(30);
        `CHK("on delay", 1'b1, alarm_status[1])
        $display("test delay done");
        bus(1, ch(2, alarm_pkg::CH_CFG), 32'h0000_0012);
        set_pv(-100);
        cyc(5);
        `CHK("latched", 3'h4, alarm_status)
        bus(1, alarm_pkg::CTRL, 32'h0000_0002);
        cyc(3);
        `CHK("cancel", 3'h0, alarm_status)
        $display("test latch done");
        set_pv(100);
        bus(1, ch(0, alarm_pkg::CH_CFG), 32'h0000_0006);
        bus(1, ch(1, alarm_pkg::CH_CFG), 32'h0000_0000);
        cyc(30);
        `CHK("standby", 3'h4, alarm_status)
        set_pv(-100);
        cyc(5);
        set_pv(100);
        cyc(5);
        `CHK("standby pass", 1'b1, alarm_status[0])
        bus(1, ch(0, alarm_pkg::CH_VALUE), 32'h0000_0000);
        cyc(5);
        `CHK("rearm value", 1'b0, alarm_status[0])
        set_pv(-100);
        set_pv(100);
        cyc(5);
        `CHK("standby again", 1'b1, alarm_status[0])
        bus(1, alarm_pkg::BANK, 32'h0000_0000);
        cyc(5);
        `CHK("rearm bank", 1'b0, alarm_status[0])
        $display("test standby done");
        bus(1, ch(1, alarm_pkg::CH_DELAY), 32'h0000_0000);
        bus(1, alarm_pkg::RAMP_SP, 32'h0000_00C8);
        bus(1, alarm_pkg::CTRL, 32'h0000_0018);
        bus(1, ch(1, alarm_pkg::CH_CFG), 32'h0000_0042);
        cyc(5);
        `CHK("sp tuning", 1'b0, alarm_status[1])
        bus(1, alarm_pkg::CTRL, 32'h0000_0008);
        cyc(5);
        `CHK("sp target", 1'b1, alarm_status[1])
        bus(1, ch(1, alarm_pkg::CH_CFG), 32'h0000_0002);
        cyc(5);
        `CHK("sp ramping", 1'b0, alarm_status[1])
        $display("test ramp done");
        set_pv(-100);
        cyc(5);
        `CHK("latch hold", 1'b1, alarm_status[2])
        bus(1, alarm_pkg::CTRL, 32'h0000_0004);
        cyc(3);
        `CHK("sreset", 1'b0, alarm_status[2])
        $display("test reset command done");
        conclude();
    end
endmodule
`default_nettype wire
